/* File: shared/ate_pkg.sv */
// Purpose: shared constants for the programmer start/busy handshake
// Assumes: 25 MHz clock, all link inputs synchronous to it
// Notes:   register offsets belong to the controller command port
package ate_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned START_MIN_MS    = 10;
  localparam int unsigned START_MIN_CYC   = (CLK_HZ / 1000) * START_MIN_MS;
  localparam int unsigned PROG_CYC_DEF    = 1000;
  // ==========================================================================
  // ports and options
  localparam int unsigned NUM_PORTS       = 4;
  localparam int unsigned NUM_OPTIONS     = 4;
  localparam int unsigned IMAGE_W         = 4;
  // ==========================================================================
  // controller register map (word offsets, byte addresses)
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_STATUS       = 8'h04;
  localparam logic [7:0] REG_OPTION       = 8'h08;
  localparam logic [7:0] REG_RESULT       = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h14;
  localparam logic [7:0] REG_DEV_OPT0     = 8'h20;
  localparam logic [7:0] REG_DEV_DEFAULT  = 8'h30;
  // control bits
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_USE_OPT    = 1;
  // irq bits
  localparam int unsigned IRQ_STARTED     = 0;
  localparam int unsigned IRQ_DONE        = 1;
  // settings layout: [3:0] port enables, [7:4] image
  localparam int unsigned SET_EN_LSB      = 0;
  localparam int unsigned SET_IMG_LSB     = 4;
  localparam logic [7:0]  SET_DEFAULT_RST = 8'h0_F;
endpackage : ate_pkg

/* File: shared/ate_link_if.sv */
// Purpose: wire-level link between programmer and test sequencer
// Assumes: open-drain busy line with pull-up resolved here
// Notes:   pass/fail lines driven by the programmer only
`timescale 1ns/1ns
interface ate_link_if;
  logic       busy_dev_oe;
  logic       busy_host_oe;
  logic       busy_line;
  logic       option_enable_n;
  logic [1:0] option_select;
  logic [3:0] port_result;
  // ==========================================================================
  // pull-up: line low while any party pulls
  assign busy_line = ~(busy_dev_oe | busy_host_oe);
  modport device (input busy_line, option_enable_n, option_select,
                  output busy_dev_oe, port_result);
  modport host   (input busy_line, port_result,
                  output busy_host_oe, option_enable_n, option_select);
endinterface : ate_link_if

/* File: hw/prog_device.sv */
// Purpose: programmer end of the start/busy handshake
// Assumes: inputs synchronous; the programming engine is modelled by a timer
// Notes:   settings are loaded through a plain write port
//
// Behaviour
// - start after line low ten milliseconds
// - hold line low until cycle finished
// - no restart before line returns high
// - sequencer releases line after start
// - program only enabled ports of setting
// - open-drain line, device only pulls low
// - results high pass, low fail
// - results valid before line rises
// - sequencer never drives result lines
// - option enable low selects by select bits
// - select 00..11 picks options 3..0
// - enable high uses stored default
// - undriven option inputs mean default; here the option lines have no pull-up
// - four stored options image plus enables
// - shared line starts every device
// - each device pulls until own finish
// - sequencer reads results separately
// - push button starts identically
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module prog_device #(
  parameter int unsigned START_MIN_CYC = ate_pkg::START_MIN_CYC,
  parameter int unsigned PROG_CYC      = ate_pkg::PROG_CYC_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  ate_link_if.device      link,
  input  wire logic       button_i,
  input  wire logic       cfg_we_i,
  input  wire logic [2:0] cfg_sel_i,
  input  wire logic [7:0] cfg_data_i,
  input  wire logic [3:0] port_ok_i,
  output logic            busy_o,
  output logic [3:0]      image_o,
  output logic [3:0]      port_en_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_WAIT = 3'b100
  } dev_state_e;

  // ==========================================================================
  // input synchronisers
  // two flops per pin; only the second stage feeds the logic
  logic [1:0] busy_sync, oen_sync, btn_sync;
  logic [1:0] sel_s1, sel_s2;
  logic [1:0] next_busy_sync, next_oen_sync, next_btn_sync;
  logic [1:0] next_sel_s1, next_sel_s2;

  always_comb begin
    next_busy_sync = {busy_sync[0], link.busy_line};
    next_oen_sync  = {oen_sync[0], link.option_enable_n};
    next_btn_sync  = {btn_sync[0], button_i};
    next_sel_s1    = link.option_select;
    next_sel_s2    = sel_s1;
    if (rst_i) begin
      // idle levels, so no false start follows reset
      next_busy_sync = 2'b11;
      next_oen_sync  = 2'b11;
      next_btn_sync  = 2'b00;
      next_sel_s1    = 2'b11;
      next_sel_s2    = 2'b11;
    end
  end

  always_ff @(posedge clk_i) begin
    busy_sync <= next_busy_sync;
    oen_sync  <= next_oen_sync;
    btn_sync  <= next_btn_sync;
    sel_s1    <= next_sel_s1;
    sel_s2    <= next_sel_s2;
  end

  wire line_low = ~busy_sync[1];

  // ==========================================================================
  // stored settings: index 0..3 options, 4 default
  logic [7:0] setting      [0:4];
  logic [7:0] next_setting [0:4];

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_setting[i] = setting[i];
      if (rst_i) begin
        next_setting[i] = ate_pkg::SET_DEFAULT_RST;
      end else if (cfg_we_i && cfg_sel_i == 3'(i)) begin
        next_setting[i] = cfg_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      setting[i] <= next_setting[i];
    end
  end

  // field views of one setting word
  function automatic logic [3:0] en_of(input logic [7:0] s);
    en_of = s[ate_pkg::SET_EN_LSB +: 4];
  endfunction : en_of

  function automatic logic [3:0] img_of(input logic [7:0] s);
    img_of = s[ate_pkg::SET_IMG_LSB +: 4];
  endfunction : img_of

  // decode option pins to setting index
  function automatic logic [2:0] pick(input logic oen, input logic [1:0] sel);
    if (oen) pick = 3'h4;
    else     pick = {1'b0, ~sel};
  endfunction : pick

  // ==========================================================================
  // handshake state
  dev_state_e state, next_state;
  logic [31:0] cnt, next_cnt;
  logic        pull, next_pull;
  logic [3:0]  res, next_res;
  logic [7:0]  act, next_act;
  logic [3:0]  en_q, next_en;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_pull  = pull;
    next_res   = res;
    next_act   = act;
    unique case (state)
      S_IDLE: begin
        if (btn_sync[1]) begin
          next_state = S_RUN;
          next_pull  = 1'b1;
          next_cnt   = 32'h0000_0000;
          next_act   = setting[pick(oen_sync[1], sel_s2)];
        end else if (!line_low) begin
          next_cnt = 32'h0000_0000;
        end else if (cnt + 32'h0000_0001 >= START_MIN_CYC) begin
          next_state = S_RUN;
          next_pull  = 1'b1;
          next_cnt   = 32'h0000_0000;
          next_act   = setting[pick(oen_sync[1], sel_s2)];
        end else begin
          next_cnt = cnt + 32'h0000_0001;
        end
      end
      S_RUN: begin
        if (cnt + 32'h0000_0001 >= PROG_CYC) begin
          // results set one cycle before release
          next_res   = port_ok_i & en_of(act);
          next_state = S_WAIT;
          next_cnt   = 32'h0000_0000;
        end else begin
          next_cnt = cnt + 32'h0000_0001;
        end
      end
      S_WAIT: begin
        next_pull = 1'b0;
        // a still-held line cannot restart us
        if (!pull && !line_low) next_state = S_IDLE;
      end
    endcase
    // registered so the enables leave straight from a flop
    next_en = (next_state == S_RUN) ? en_of(next_act) : 4'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt   <= 32'h0000_0000;
      pull  <= 1'b0;
      res   <= 4'h0;
      act   <= 8'h00;
      en_q  <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      pull  <= next_pull;
      res   <= next_res;
      act   <= next_act;
      en_q  <= next_en;
    end
  end


  assign link.busy_dev_oe = pull;
  assign link.port_result = res;
  assign busy_o    = pull;
  assign image_o   = img_of(act);
  assign port_en_o = en_q;
endmodule : prog_device

/* File: hw/ate_host.sv */
// Purpose: test-sequencer end of the start/busy handshake
// Assumes: inputs synchronous to clk_i
// Notes:   controlled by a plain register port
`timescale 1ns/1ns
module ate_host #(
  parameter int unsigned START_MIN_CYC = ate_pkg::START_MIN_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  ate_link_if.host        link,
  input  wire logic [7:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [31:0]     rdata_o,
  output logic            irq_o
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_PULL = 4'b0010,
    H_BUSY = 4'b0100,
    H_REL  = 4'b1000
  } host_state_e;

  host_state_e state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [1:0]  opt, irq_st, irq_mask, next_irq;
  logic        use_opt, pull, line_q;
  logic [3:0]  result;

  // ==========================================================================
  // sequencer
  wire start_req = wr_i && addr_i == ate_pkg::REG_CTRL && wdata_i[ate_pkg::CTRL_START_BIT];
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      H_IDLE: if (start_req && line_q) begin
        next_state = H_PULL;
        next_cnt   = 32'h0000_0000;
      end
      H_PULL: begin
        next_cnt = cnt + 32'h0000_0001;
        if (cnt + 32'h0000_0001 >= START_MIN_CYC + 32'h0000_0004) next_state = H_BUSY;
      end
      H_BUSY: next_state = H_REL;
      H_REL:  if (line_q) next_state = H_IDLE;
    endcase
  end

  // rising edge of line: sample results
  wire rise = line_q == 1'b0 && link.busy_line && state == H_REL;
  always_comb begin
    next_irq = irq_st;
    if (wr_i && addr_i == ate_pkg::REG_IRQ_STATUS) next_irq = irq_st & ~wdata_i[1:0];
    // set wins over clear
    if (state == H_PULL && next_state == H_BUSY) next_irq[ate_pkg::IRQ_STARTED] = 1'b1;
    if (rise) next_irq[ate_pkg::IRQ_DONE] = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= H_IDLE;
      cnt      <= 32'h0000_0000;
      line_q   <= 1'b1;
      result   <= 4'h0;
      irq_st   <= 2'b00;
      irq_mask <= 2'b00;
      opt      <= 2'b11;
      use_opt  <= 1'b0;
      rdata_o  <= 32'h0000_0000;
      irq_o    <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      line_q <= link.busy_line;
      if (rise) result <= link.port_result;
      irq_st <= next_irq;
      irq_o  <= |(next_irq & irq_mask);
      if (wr_i && addr_i == ate_pkg::REG_IRQ_MASK) irq_mask <= wdata_i[1:0];
      if (wr_i && addr_i == ate_pkg::REG_OPTION) opt <= wdata_i[1:0];
      if (wr_i && addr_i == ate_pkg::REG_CTRL) use_opt <= wdata_i[ate_pkg::CTRL_USE_OPT];
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        unique case (addr_i)
          ate_pkg::REG_CTRL:       rdata_o <= {30'h0, use_opt, 1'b0};
          ate_pkg::REG_STATUS:     rdata_o <= {28'h0, state};
          ate_pkg::REG_OPTION:     rdata_o <= {30'h0, opt};
          ate_pkg::REG_RESULT:     rdata_o <= {28'h0, result};
          ate_pkg::REG_IRQ_STATUS: rdata_o <= {30'h0, irq_st};
          ate_pkg::REG_IRQ_MASK:   rdata_o <= {30'h0, irq_mask};
          default:                 rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign link.busy_host_oe    = state == H_PULL;
  assign link.option_enable_n = ~use_opt;
  assign link.option_select   = opt;
endmodule : ate_host

/* File: tb/ate_program_handshake_asserts.sv */
// Purpose: wire-level checks on the start/busy link between both ends
// Assumes: one clock, synchronous active-high reset
// Notes:   counters are ints so a long run never wraps them
`timescale 1ns/1ns
module ate_program_handshake_asserts #(
  parameter int unsigned START_MIN_CYC = 20,
  parameter int unsigned PROG_CYC      = 30
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       busy_dev_oe,
  input wire logic       busy_host_oe,
  input wire logic       busy_line,
  input wire logic       option_enable_n,
  input wire logic [1:0] option_select,
  input wire logic [3:0] port_result
);
  logic        rst_d;
  logic        armed;
  int unsigned low_cnt;
  int unsigned dev_cnt;
  int unsigned host_cnt;
  // ==========================================================================
  // helper counters
  always_ff @(posedge clk_i) begin
    rst_d    <= rst_i;
    armed    <= (rst_i | busy_line) ? 1'b1 : (busy_dev_oe ? 1'b0 : armed);
    low_cnt  <= (rst_i | busy_line) ? 0 : low_cnt + 1;
    dev_cnt  <= (rst_i | ~busy_dev_oe) ? 0 : dev_cnt + 1;
    host_cnt <= (rst_i | ~busy_host_oe) ? 0 : host_cnt + 1;
  end
  // ==========================================================================
  // properties
  // past values straddle reset for one edge, so that edge is skipped too
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || rst_d);
  AST_START_LOW: assert property ($rose(busy_dev_oe) && !$past(busy_line) |->
    low_cnt >= START_MIN_CYC)
    else $error("device pulled before line was low long enough");
  AST_START_DUE: assert property (low_cnt == START_MIN_CYC + 8 |-> busy_dev_oe)
    else $error("device did not start after a long low");
  AST_NO_RESTART: assert property ($rose(busy_dev_oe) |-> armed)
    else $error("device restarted without line going high");
  AST_HOLD_LEN: assert property ($fell(busy_dev_oe) |->
    dev_cnt >= PROG_CYC - 1 && dev_cnt <= PROG_CYC + 1)
    else $error("device pull length wrong");
  AST_HOST_RELEASE: assert property ($rose(busy_dev_oe) |-> ##[0:8] !busy_host_oe)
    else $error("sequencer kept pulling after start");
  AST_HOST_MIN: assert property ($fell(busy_host_oe) |-> host_cnt >= START_MIN_CYC)
    else $error("sequencer pull too short");
  AST_OPT_STABLE: assert property (busy_host_oe && $past(busy_host_oe) |->
    $stable({option_enable_n, option_select}))
    else $error("option lines moved during start pull");
  AST_RESULT_VALID: assert property ($rose(busy_line) |-> $stable(port_result))
    else $error("results changed at line rise");
  AST_RESULT_HOLD: assert property (!busy_dev_oe && $past(!busy_dev_oe) |->
    $stable(port_result))
    else $error("results changed while idle");
endmodule : ate_program_handshake_asserts

/* File: tb/tb_ate_program_handshake.sv */
// Purpose: runs both ends through every option setting
// Assumes: shortened start and program counts
// Notes:   push button pulsed once after the link scenarios
`timescale 1ns/1ns
module tb_ate_program_handshake;
  localparam int unsigned SMIN = 20;
  localparam int unsigned PCYC = 30;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        button = 1'b0;
  logic        cfg_we = 1'b0;
  logic [2:0]  cfg_sel = 3'h0;
  logic [7:0]  cfg_data = 8'h00;
  logic [3:0]  port_ok = 4'h0;
  logic        busy;
  logic [3:0]  image;
  logic [3:0]  port_en;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic [31:0] seed = 32'h3c3e_1c3e;
  int          bad_count = 0;
  int          checks_done = 0;
  always #20 clk = ~clk;
  ate_link_if link ();
  prog_device #(.START_MIN_CYC(SMIN), .PROG_CYC(PCYC)) i_prog_device (.clk_i(clk),
    .rst_i(rst), .link(link.device), .button_i(button), .cfg_we_i(cfg_we), .cfg_sel_i(cfg_sel),
    .cfg_data_i(cfg_data), .port_ok_i(port_ok), .busy_o(busy), .image_o(image),
    .port_en_o(port_en));
  ate_host #(.START_MIN_CYC(SMIN)) i_ate_host (.clk_i(clk), .rst_i(rst), .link(link.host),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
  ate_program_handshake_asserts #(.START_MIN_CYC(SMIN), .PROG_CYC(PCYC))
    i_ate_program_handshake_asserts (.clk_i(clk), .rst_i(rst),
    .busy_dev_oe(link.busy_dev_oe), .busy_host_oe(link.busy_host_oe),
    .busy_line(link.busy_line), .option_enable_n(link.option_enable_n),
    .option_select(link.option_select), .port_result(link.port_result));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask : reg_rd
  // bounded wait; a timeout shows as a busy mismatch
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    #1;
    while (busy !== lvl && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(busy, lvl);
  endtask : wait_busy
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // main sequence
  initial begin
    logic [7:0] cfg [0:4];
    logic [7:0] exp_cfg;
    logic [1:0] sel;
    logic       opt;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(link.option_enable_n, 1'b1);
    reg_rd(ate_pkg::REG_IRQ_STATUS, 32'h0000_0000);
    reg_rd(8'h40, 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      cfg[k] = seed[7:0];
      @(posedge clk);
      cfg_we   <= 1'b1;
      cfg_sel  <= 3'(k);
      cfg_data <= cfg[k];
    end
    @(posedge clk);
    cfg_we <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      opt = (k < 4);
      sel = opt ? 2'(k) : seed[9:8];
      exp_cfg = opt ? cfg[3 - sel] : cfg[4];
      port_ok <= seed[3:0];
      reg_wr(ate_pkg::REG_IRQ_MASK, {30'h0, k[0], 1'b0});
      reg_wr(ate_pkg::REG_OPTION, {30'h0, sel});
      reg_wr(ate_pkg::REG_CTRL, {30'h0, opt, 1'b1});
      wait_busy(1'b1);
      chk(image, exp_cfg[7:4]);
      chk(port_en, exp_cfg[3:0]);
      wait_busy(1'b0);
      repeat (4) @(posedge clk);
      #1 chk(link.port_result, exp_cfg[3:0] & seed[3:0]);
      reg_rd(ate_pkg::REG_RESULT, {28'h0, exp_cfg[3:0] & seed[3:0]});
      chk(irq, k[0]);
      reg_rd(ate_pkg::REG_IRQ_STATUS, 32'h0000_0003);
      reg_wr(ate_pkg::REG_IRQ_STATUS, 32'h0000_0003);
      @(posedge clk);
      #1 chk(irq, 1'b0);
    end
    // last loop pass left option enable off, so default applies
    @(posedge clk);
    button <= 1'b1;
    @(posedge clk);
    button <= 1'b0;
    wait_busy(1'b1);
    chk(image, cfg[4][7:4]);
    chk(port_en, cfg[4][3:0]);
    wait_busy(1'b0);
    repeat (4) @(posedge clk);
    #1 chk(link.port_result, cfg[4][3:0] & port_ok);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : tb_ate_program_handshake
